// [design/irq_flag_pkg.sv]
package irq_flag_pkg;

    // Register byte addresses (one aligned word each)
    localparam logic [7:0] ADDR_FLAGS5   = 8'h00;
    localparam logic [7:0] ADDR_FLAGS6   = 8'h04;
    localparam logic [7:0] ADDR_FLAGS7   = 8'h08;
    localparam logic [7:0] ADDR_ENABLE5  = 8'h0c;
    localparam logic [7:0] ADDR_ENABLE6  = 8'h10;
    localparam logic [7:0] ADDR_ENABLE7  = 8'h14;
    localparam logic [7:0] ADDR_CONTROL  = 8'h18;
    localparam logic [7:0] ADDR_MODE     = 8'h1c;

    // Implemented-bit masks of the three flag registers
    localparam logic [7:0] MASK_FLAGS5   = 8'hf1;
    localparam logic [7:0] MASK_FLAGS6   = 8'h03;
    localparam logic [7:0] MASK_FLAGS7   = 8'h31;
    // Control: bit 7 global enable, bit 6 peripheral enable, bit 0 edge
    localparam logic [7:0] MASK_CONTROL  = 8'hc1;
    localparam int         BIT_GLOBAL    = 7;
    localparam int         BIT_PERIPH    = 6;
    localparam logic [7:0] RESET_BYTE    = 8'h00;

    // Flag positions
    localparam int         BIT_CELL_LO   = 4;
    localparam int         BIT_GATE      = 0;
    localparam int         BIT_UNIT_ONE  = 0;
    localparam int         BIT_UNIT_TWO  = 1;
    localparam int         BIT_NVM       = 5;
    localparam int         BIT_ROLLOVER  = 4;
    localparam int         BIT_SHUTDOWN  = 0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // Capture unit operating mode
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_PWM
    } unit_mode_type;

    // Event pulses from the peripherals
    typedef struct packed {
        logic [3:0] logicCell;
        logic       gateInactive;
        logic [1:0] captureEvent;
        logic [1:0] compareMatch;
        logic [1:0] pwmTrailing;
        logic       memoryOpDone;
        logic       oscRollover;
        logic       waveShutdown;
    } event_type;

    // AHB-Lite slave inputs
    typedef struct packed {
        logic        hsel;
        logic [7:0]  haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } ahb_req_type;

endpackage

// [design/peripheral_interrupt_flag_bank.sv]
`timescale 1ns/1ps
module peripheral_interrupt_flag_bank (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire irq_flag_pkg::event_type    events,
    input  wire irq_flag_pkg::ahb_req_type  ahbReq,
    output logic [31:0]                     hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic                            periphIrq,
    output logic                            edgeSelect,
    output logic [1:0]                      unitOneMode,
    output logic [1:0]                      unitTwoMode
);
    import irq_flag_pkg::*;

    logic [7:0]  flags5_r, flags6_r, flags7_r;
    logic [7:0]  flags5_nxt, flags6_nxt, flags7_nxt;
    logic [7:0]  enable5_r, enable6_r, enable7_r, control_r, mode_r;
    logic [7:0]  enable5_nxt, enable6_nxt, enable7_nxt;
    logic [7:0]  control_nxt, mode_nxt;
    logic        wrPend_r, wrPend_nxt;
    logic [7:0]  wrAddr_r, wrAddr_nxt;
    logic [31:0] rdata_nxt;
    logic        irq_nxt;
    logic        addrPhase;
    logic [7:0]  set5, set6, set7, wbyte;
    unit_mode_type modeOne, modeTwo;

    // Only NONSEQ transfers take effect, writes only when whole-word; slave is zero-wait
    assign addrPhase = ahbReq.hsel && ahbReq.hready
                       && ahbReq.htrans == HTRANS_NONSEQ;
    assign wbyte     = ahbReq.hwdata[7:0];
    assign modeOne   = unit_mode_type'(mode_r[1:0]);
    assign modeTwo   = unit_mode_type'(mode_r[3:2]);

    // Hardware set vectors built per flag position
    always_comb begin
        set5 = RESET_BYTE;
        set6 = RESET_BYTE;
        set7 = RESET_BYTE;
        set5[BIT_CELL_LO +: 4] = events.logicCell;
        set5[BIT_GATE] = events.gateInactive;
        set6[BIT_UNIT_ONE] =
            (modeOne == MODE_CAPTURE && events.captureEvent[0])
            || (modeOne == MODE_COMPARE && events.compareMatch[0])
            || (modeOne == MODE_PWM && events.pwmTrailing[0]);
        set6[BIT_UNIT_TWO] =
            (modeTwo == MODE_CAPTURE && events.captureEvent[1])
            || (modeTwo == MODE_COMPARE && events.compareMatch[1])
            || (modeTwo == MODE_PWM && events.pwmTrailing[1]);
        set7[BIT_NVM] = events.memoryOpDone;
        set7[BIT_ROLLOVER] = events.oscRollover;
        set7[BIT_SHUTDOWN] = events.waveShutdown;
    end

    // Register file next state; writes land in the data phase
    always_comb begin
        flags5_nxt  = flags5_r;
        flags6_nxt  = flags6_r;
        flags7_nxt  = flags7_r;
        enable5_nxt = enable5_r;
        enable6_nxt = enable6_r;
        enable7_nxt = enable7_r;
        control_nxt = control_r;
        mode_nxt    = mode_r;
        wrPend_nxt  = addrPhase && ahbReq.hwrite
                      && ahbReq.hsize == HSIZE_WORD;
        wrAddr_nxt  = ahbReq.haddr;
        if (wrPend_r) begin
            case (wrAddr_r)
                ADDR_FLAGS5:  flags5_nxt  = wbyte & MASK_FLAGS5;
                ADDR_FLAGS6:  flags6_nxt  = wbyte & MASK_FLAGS6;
                ADDR_FLAGS7:  flags7_nxt  = wbyte & MASK_FLAGS7;
                ADDR_ENABLE5: enable5_nxt = wbyte & MASK_FLAGS5;
                ADDR_ENABLE6: enable6_nxt = wbyte & MASK_FLAGS6;
                ADDR_ENABLE7: enable7_nxt = wbyte & MASK_FLAGS7;
                ADDR_CONTROL: control_nxt = wbyte & MASK_CONTROL;
                ADDR_MODE:    mode_nxt    = wbyte;
                default:      mode_nxt    = mode_r;
            endcase
        end
        // Set applied after the write so a same-cycle event is kept
        flags5_nxt = flags5_nxt | set5;
        flags6_nxt = flags6_nxt | set6;
        flags7_nxt = flags7_nxt | set7;
    end

    // Read data and request output, both registered
    always_comb begin
        rdata_nxt = '0;
        if (addrPhase && !ahbReq.hwrite) begin
            case (ahbReq.haddr)
                ADDR_FLAGS5:  rdata_nxt[7:0] = flags5_nxt;
                ADDR_FLAGS6:  rdata_nxt[7:0] = flags6_nxt;
                ADDR_FLAGS7:  rdata_nxt[7:0] = flags7_nxt;
                ADDR_ENABLE5: rdata_nxt[7:0] = enable5_nxt;
                ADDR_ENABLE6: rdata_nxt[7:0] = enable6_nxt;
                ADDR_ENABLE7: rdata_nxt[7:0] = enable7_nxt;
                ADDR_CONTROL: rdata_nxt[7:0] = control_nxt;
                ADDR_MODE:    rdata_nxt[7:0] = mode_nxt;
                default:      rdata_nxt      = '0;
            endcase
        end
        irq_nxt = control_nxt[BIT_GLOBAL] && control_nxt[BIT_PERIPH]
                  && |{flags5_nxt & enable5_nxt,
                       flags6_nxt & enable6_nxt,
                       flags7_nxt & enable7_nxt};
    end

    // All state clears on reset; flags start at zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags5_r  <= RESET_BYTE;
            flags6_r  <= RESET_BYTE;
            flags7_r  <= RESET_BYTE;
            enable5_r <= RESET_BYTE;
            enable6_r <= RESET_BYTE;
            enable7_r <= RESET_BYTE;
            control_r <= RESET_BYTE;
            mode_r    <= RESET_BYTE;
            wrPend_r  <= 1'b0;
            wrAddr_r  <= RESET_BYTE;
            hrdata    <= '0;
            periphIrq <= 1'b0;
        end else begin
            flags5_r  <= flags5_nxt;
            flags6_r  <= flags6_nxt;
            flags7_r  <= flags7_nxt;
            enable5_r <= enable5_nxt;
            enable6_r <= enable6_nxt;
            enable7_r <= enable7_nxt;
            control_r <= control_nxt;
            mode_r    <= mode_nxt;
            wrPend_r  <= wrPend_nxt;
            wrAddr_r  <= wrAddr_nxt;
            hrdata    <= rdata_nxt;
            periphIrq <= irq_nxt;
        end
    end

    // Zero-wait OKAY slave; config pins straight from registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            edgeSelect  <= 1'b0;
            unitOneMode <= 2'h0;
            unitTwoMode <= 2'h0;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            edgeSelect  <= control_nxt[0];
            unitOneMode <= mode_nxt[1:0];
            unitTwoMode <= mode_nxt[3:2];
        end
    end

    // Checks
    a_cell_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
        events.logicCell[0] |=> flags5_r[BIT_CELL_LO])
        else $error("cell flag not set");
    a_gate_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
        events.gateInactive |=> flags5_r[BIT_GATE])
        else $error("gate flag not set");
    a_capture_sets: assert property (@(posedge clk_sys) disable iff (rst)
        modeOne == MODE_CAPTURE && events.captureEvent[0]
        |=> flags6_r[BIT_UNIT_ONE])
        else $error("capture flag not set");
    a_compare_sets: assert property (@(posedge clk_sys) disable iff (rst)
        modeTwo == MODE_COMPARE && events.compareMatch[1]
        |=> flags6_r[BIT_UNIT_TWO])
        else $error("compare flag not set");
    a_pwm_sets: assert property (@(posedge clk_sys) disable iff (rst)
        modeOne == MODE_PWM && events.pwmTrailing[0]
        |=> flags6_r[BIT_UNIT_ONE])
        else $error("pwm flag not set");
    a_memory_sets: assert property (@(posedge clk_sys) disable iff (rst)
        events.memoryOpDone |=> flags7_r[BIT_NVM])
        else $error("memory flag not set");
    a_rollover_sets: assert property (@(posedge clk_sys) disable iff (rst)
        events.oscRollover |=> flags7_r[BIT_ROLLOVER])
        else $error("rollover flag not set");
    a_shutdown_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        flags7_r[BIT_SHUTDOWN] && !wrPend_r |=> flags7_r[BIT_SHUTDOWN])
        else $error("shutdown flag dropped");
    a_unused_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (flags5_r & ~MASK_FLAGS5) == 0 && (flags6_r & ~MASK_FLAGS6) == 0
        && (flags7_r & ~MASK_FLAGS7) == 0)
        else $error("unimplemented bit set");
    a_set_beats_clr: assert property (@(posedge clk_sys) disable iff (rst)
        wrPend_r && wrAddr_r == ADDR_FLAGS7 && events.oscRollover
        |=> flags7_r[BIT_ROLLOVER])
        else $error("set lost to clear");
    a_irq_gating: assert property (@(posedge clk_sys) disable iff (rst)
        !control_r[BIT_GLOBAL] |-> !periphIrq)
        else $error("irq without global enable");
    a_flags_cleared: assert property (@(posedge clk_sys)
        $fell(rst) |-> flags5_r == 0 && flags6_r == 0 && flags7_r == 0)
        else $error("flags not reset");

    a_unit_off_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        modeOne == MODE_OFF && modeTwo == MODE_OFF && !wrPend_r
        |=> flags6_r == $past(flags6_r))
        else $error("unit flag set while off");
    a_irq_follows: assert property (@(posedge clk_sys) disable iff (rst)
        control_r[BIT_GLOBAL] && control_r[BIT_PERIPH]
        && (flags7_r & enable7_r) != 0 |-> periphIrq)
        else $error("irq missing with enables set");

    c_irq_raised: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(periphIrq));
    c_set_vs_clear: cover property (@(posedge clk_sys) disable iff (rst)
        wrPend_r && wrAddr_r == ADDR_FLAGS5 && |set5);
    c_pwm_event: cover property (@(posedge clk_sys) disable iff (rst)
        modeTwo == MODE_PWM && events.pwmTrailing[1]);
endmodule

// [test/event_source.sv]
`timescale 1ns/1ps
module event_source (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire irq_flag_pkg::event_type fire,
    output irq_flag_pkg::event_type      events
);
    import irq_flag_pkg::*;
    // Registered copies of the fire pulses, one cycle late, as a peripheral's own event logic gives
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            events <= '0;
        end else begin
            events <= fire;
        end
    end
endmodule

// [test/peripheral_interrupt_flag_bank_tb.sv]
`timescale 1ns/1ps
module peripheral_interrupt_flag_bank_tb;
    import irq_flag_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    event_type   fire;
    event_type   events;
    event_type   ev;
    event_type   bad;
    ahb_req_type req;
    ahb_req_type ahb;
    logic [31:0] hrdata;
    logic [31:0] rdSmp;
    logic [31:0] q;
    logic        hreadyout;
    logic        hresp;
    logic        rdyS;
    logic        periphIrq;
    logic        edgeSelect;
    logic [1:0]  unitOneMode;
    logic [1:0]  unitTwoMode;
    logic [7:0]  addrs [8];
    logic [7:0]  masks [8];
    logic [7:0]  ctl [3];
    int          n_errors = 0;
    int          n_tests = 0;

    always #10 clk_sys = ~clk_sys;
    // The single slave's hreadyout is the bus hready
    always_comb begin
        ahb = req;
        ahb.hready = hreadyout;
    end
    // Bus answers are taken as they stood just before the edge
    always @(posedge clk_sys) begin
        rdSmp <= hrdata;
        rdyS <= hreadyout;
    end

    peripheral_interrupt_flag_bank u_peripheral_interrupt_flag_bank (
        .clk_sys(clk_sys), .rst(rst), .events(events), .ahbReq(ahb),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .periphIrq(periphIrq), .edgeSelect(edgeSelect),
        .unitOneMode(unitOneMode), .unitTwoMode(unitTwoMode));
    event_source u_event_source (
        .clk_sys(clk_sys), .rst(rst), .fire(fire), .events(events));

    task summarize;
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for hready sampled high at a rising edge
    task waitRdy;
        int k;
        k = 0;
        do begin
            @(posedge clk_sys);
            #1;
            k++;
        end while (rdyS !== 1'b1 && k < 20);
        if (rdyS !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t bus hang", $time);
            summarize();
        end
    endtask
    // Upper data bits are junk on purpose: only the low byte may count
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
             input event_type e);
        req.hsel <= 1'b1;
        req.haddr <= a;
        req.htrans <= HTRANS_NONSEQ;
        req.hwrite <= w;
        req.hsize <= HSIZE_WORD;
        fire <= e;
        waitRdy();
        req.hsel <= 1'b0;
        req.htrans <= 2'h0;
        req.hwdata <= {24'ha5a5a5, d};
        fire <= '0;
        waitRdy();
        q = rdSmp;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, '0);
    endtask
    task rdChk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, '0);
        chk(q, {24'h0, exp});
    endtask
    task pulse(input event_type e);
        fire <= e;
        repeat (2) @(posedge clk_sys);
        #1;
        fire <= '0;
    endtask
    task settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    initial begin
        #1500000;
        n_errors++;
        $display("[ERR] %0t run timeout", $time);
        summarize();
    end

    initial begin
        req = '0;
        fire = '0;
        addrs = '{ADDR_FLAGS5, ADDR_FLAGS6, ADDR_FLAGS7, ADDR_ENABLE5,
                  ADDR_ENABLE6, ADDR_ENABLE7, ADDR_CONTROL, ADDR_MODE};
        masks = '{MASK_FLAGS5, MASK_FLAGS6, MASK_FLAGS7, MASK_FLAGS5,
                  MASK_FLAGS6, MASK_FLAGS7, MASK_CONTROL, 8'hff};
        ctl = '{8'h80, 8'h40, 8'hc0};
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
        for (int i = 0; i < 8; i++) rdChk(addrs[i], RESET_BYTE);
        for (int i = 0; i < 8; i++) begin
            wr(addrs[i], 8'hff);
            rdChk(addrs[i], masks[i]);
            wr(addrs[i], 8'h00);
            rdChk(addrs[i], 8'h00);
        end
        wr(8'h20, 8'hff);
        rdChk(8'h20, 8'h00);
        $display("test registers done");
        ev = '0;
        ev.logicCell = 4'hf;
        ev.gateInactive = 1'b1;
        pulse(ev);
        rdChk(ADDR_FLAGS5, 8'hf1);
        wr(ADDR_FLAGS5, 8'h00);
        // Both units are still off: no unit event may set a flag
        ev = '0;
        ev.captureEvent = 2'h3;
        ev.compareMatch = 2'h3;
        ev.pwmTrailing = 2'h3;
        pulse(ev);
        rdChk(ADDR_FLAGS6, 8'h00);
        for (int m = 1; m < 4; m++) begin
            wr(ADDR_MODE, {4'h0, m[1:0], m[1:0]});
            chk({28'h0, unitTwoMode, unitOneMode},
                {28'h0, m[1:0], m[1:0]});
            ev = '0;
            bad = '0;
            case (m)
                1: begin ev.captureEvent = 2'h3; bad.compareMatch = 2'h3; end
                2: begin ev.compareMatch = 2'h3; bad.pwmTrailing = 2'h3; end
                default: begin ev.pwmTrailing = 2'h3; bad.captureEvent = 2'h3; end
            endcase
            pulse(bad);
            rdChk(ADDR_FLAGS6, 8'h00);
            pulse(ev);
            rdChk(ADDR_FLAGS6, 8'h03);
            wr(ADDR_FLAGS6, 8'h00);
        end
        ev = '0;
        ev.memoryOpDone = 1'b1;
        pulse(ev);
        rdChk(ADDR_FLAGS7, 8'h20);
        ev = '0;
        ev.oscRollover = 1'b1;
        pulse(ev);
        rdChk(ADDR_FLAGS7, 8'h30);
        ev = '0;
        ev.waveShutdown = 1'b1;
        pulse(ev);
        rdChk(ADDR_FLAGS7, 8'h31);
        wr(ADDR_FLAGS7, 8'h01);
        ev = '0;
        ev.oscRollover = 1'b1;
        bus(1'b1, ADDR_FLAGS7, 8'h00, ev);
        rdChk(ADDR_FLAGS7, 8'h10);
        $display("test events done");
        wr(ADDR_ENABLE7, 8'h10);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CONTROL, ctl[i]);
            settle();
            chk({31'h0, periphIrq}, {31'h0, i == 2});
        end
        wr(ADDR_ENABLE7, 8'h00);
        settle();
        chk({31'h0, periphIrq}, 32'h0);
        wr(ADDR_CONTROL, 8'h01);
        settle();
        chk({31'h0, edgeSelect}, 32'h1);
        $display("test request done");
        rst <= 1'b1;
        settle();
        rst <= 1'b0;
        settle();
        rdChk(ADDR_FLAGS7, 8'h00);
        rdChk(ADDR_CONTROL, 8'h00);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        $display("test second reset done");
        summarize();
    end
endmodule
